//--- bench/etdl_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module etdl_top_assertions #(
    parameter logic [15:0] PROG_TICKS = 16'h0064
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Watched signals
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic stop_mode,
    input wire logic charge_pump_en,
    input wire logic array_access_block,
    input wire logic timebase_tick,
    input wire logic program_busy
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    property p_rdata_idle;
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");
    property p_pump_busy;
        charge_pump_en |-> program_busy;
    endproperty
    a_pump_busy: assert property (p_pump_busy) else $error("pump on while idle");
    property p_pump_rise;
        $rose(charge_pump_en) |-> program_busy && !stop_mode;
    endproperty
    a_pump_rise: assert property (p_pump_rise) else $error("pump rose in stop");
    property p_stop_pump;
        stop_mode ##1 stop_mode |-> !charge_pump_en;
    endproperty
    a_stop_pump: assert property (p_stop_pump) else $error("pump on in stop");
    property p_stop_tick;
        stop_mode [*2] |-> !timebase_tick;
    endproperty
    a_stop_tick: assert property (p_stop_tick) else $error("tick in stop");
    property p_stop_halt;
        $rose(stop_mode) && $past(charge_pump_en) |-> ##[1:2] array_access_block && program_busy;
    endproperty
    a_stop_halt: assert property (p_stop_halt) else $error("no halt on stop");
    property p_exit_block;
        $fell(stop_mode) && array_access_block |=> array_access_block;
    endproperty
    a_exit_block: assert property (p_exit_block) else $error("block dropped at stop exit");
    property p_block_busy;
        array_access_block |-> program_busy;
    endproperty
    a_block_busy: assert property (p_block_busy) else $error("block without sequence");
    property p_done_pump;
        $fell(program_busy) |-> !charge_pump_en && !array_access_block;
    endproperty
    a_done_pump: assert property (p_done_pump) else $error("pump or block after end");
endmodule : etdl_top_assertions
bind etdl_top etdl_top_assertions #(.PROG_TICKS(PROG_TICKS)) u_etdl_top_assertions (.mclk(mclk), .rst_n(rst_n),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .stop_mode(stop_mode), .charge_pump_en(charge_pump_en),
    .array_access_block(array_access_block), .timebase_tick(timebase_tick), .program_busy(program_busy));
`default_nettype wire

//--- bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import etdl_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic por_n = 1'b0;
    logic [ADDR_W-1:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic xtal = 1'b0;
    logic xtal_on = 1'b0;
    logic stop_mode = 1'b0;
    logic wait_mode = 1'b0;
    logic [7:0] reg_rdata;
    logic charge_pump_en, array_access_block, timebase_tick, program_busy;
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [DIV_W-1:0] bus_div = DIV_W'(BUS_DIVISOR);
    etdl_top #(.PROG_TICKS(16'h0003)) u_etdl_top (.mclk(mclk), .rst_n(rst_n), .por_n(por_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .crystal_reference_clock(xtal), .stop_mode(stop_mode), .wait_mode(wait_mode),
        .charge_pump_en(charge_pump_en), .array_access_block(array_access_block),
        .timebase_tick(timebase_tick), .program_busy(program_busy));
    always #10 mclk = ~mclk;
    // Reference events on every other cycle, so one tick spans twice the divisor.
    always @(posedge mclk) xtal <= xtal_on & ~xtal;
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            miscompares++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata & m, e);
    endtask : rd
    task automatic wait_busy(input logic lvl);
        int i;
        #1;
        i = 0;
        while (program_busy !== lvl && i < 6000)
        begin
            @(posedge mclk);
            #1;
            i++;
        end
        chk({7'h00, program_busy}, {7'h00, lvl});
    endtask : wait_busy
    task automatic tick_gap(input logic [7:0] e);
        int c;
        c = 0;
        @(posedge mclk);
        #1;
        while (timebase_tick !== 1'b1 && c < 100)
        begin
            @(posedge mclk);
            #1;
            c++;
        end
        c = 0;
        do
        begin
            @(posedge mclk);
            #1;
            c++;
        end while (timebase_tick !== 1'b1 && c < 100);
        chk(8'(c), e);
    endtask : tick_gap
    // Latch, capture the target, then raise program enable with bus-clock reference kept.
    task automatic prog(input logic [2:0] a, input logic [7:0] d);
        wr(OFF_CONTROL, 8'h09);
        wr(a, d);
        wr(OFF_CONTROL, 8'h0B);
        wait_busy(1'b1);
    endtask : prog
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        repeat (2) @(posedge mclk);
        rd(OFF_DIV_HIGH, 8'hFF, 8'h87);
        rd(OFF_DIV_LOW, 8'hFF, 8'hFF);
        rd(3'h6, 8'hFF, 8'h00);
        wr(OFF_DIV_HIGH, 8'h80);
        wr(OFF_DIV_LOW, 8'h04);
        rd(OFF_DIV_HIGH, 8'hFF, 8'h80);
        rd(OFF_DIV_LOW, 8'hFF, 8'h04);
        wr(OFF_CONTROL, 8'h09);
        wr(OFF_DIV_LOW, 8'h09);
        rd(OFF_DIV_LOW, 8'hFF, 8'h04);
        tick_gap(8'h04);
        wr(OFF_CONTROL, 8'h01);
        xtal_on <= 1'b1;
        tick_gap(8'h08);
        xtal_on <= 1'b0;
        wr(OFF_CONTROL, 8'h08);
        wr(OFF_DIV_HIGH, {1'b1, 4'h0, bus_div[10:8]});
        wr(OFF_DIV_LOW, bus_div[7:0]);
        rd(OFF_DIV_LOW, 8'hFF, bus_div[7:0]);
        $display("test divisor done");
        prog(OFF_SHADOW_LOW, 8'h05);
        @(posedge mclk);
        wait_mode <= 1'b1;
        @(posedge mclk);
        #1;
        chk({7'h00, charge_pump_en}, 8'h01);
        rd(OFF_STATUS, 8'h21, 8'h21);
        wait_busy(1'b0);
        @(posedge mclk);
        wait_mode <= 1'b0;
        wr(OFF_CONTROL, 8'h08);
        rd(OFF_SHADOW_LOW, 8'hFF, 8'h05);
        wr(OFF_CONTROL, 8'h0D);
        wr(OFF_SHADOW_LOW, 8'h00);
        wr(OFF_CONTROL, 8'h0F);
        wait_busy(1'b1);
        wait_busy(1'b0);
        wr(OFF_CONTROL, 8'h0C);
        rd(OFF_SHADOW_LOW, 8'hFF, 8'hFF);
        $display("test program done");
        prog(OFF_SHADOW_LOW, 8'h05);
        repeat (2) @(posedge mclk);
        stop_mode <= 1'b1;
        repeat (4) @(posedge mclk);
        stop_mode <= 1'b0;
        #1;
        chk({5'h00, charge_pump_en, array_access_block, program_busy}, 8'h03);
        repeat (2) @(posedge mclk);
        #1;
        chk({7'h00, array_access_block}, 8'h01);
        rd(OFF_SHADOW_LOW, 8'hFF, 8'h00);
        wait_busy(1'b0);
        chk({7'h00, array_access_block}, 8'h00);
        wr(OFF_CONTROL, 8'h08);
        wr(OFF_CONTROL, 8'h09);
        wr(OFF_SHADOW_LOW, 8'h05);
        stop_mode <= 1'b1;
        repeat (2) @(posedge mclk);
        stop_mode <= 1'b0;
        rd(OFF_STATUS, 8'h08, 8'h00);
        wr(OFF_CONTROL, 8'h0B);
        repeat (3) @(posedge mclk);
        #1;
        chk({7'h00, program_busy}, 8'h00);
        wr(OFF_CONTROL, 8'h08);
        $display("test stop done");
        prog(OFF_SHADOW_HIGH, 8'h00);
        wait_busy(1'b0);
        wr(OFF_CONTROL, 8'h00);
        rst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        rd(OFF_DIV_HIGH, 8'hFF, 8'h00);
        rd(OFF_DIV_LOW, 8'hFF, 8'h05);
        rd(OFF_STATUS, 8'h04, 8'h04);
        wr(OFF_DIV_HIGH, 8'h80);
        wr(OFF_DIV_LOW, 8'h01);
        rd(OFF_DIV_HIGH, 8'hFF, 8'h00);
        rd(OFF_DIV_LOW, 8'hFF, 8'h05);
        wr(OFF_CONTROL, 8'h09);
        wr(OFF_SHADOW_LOW, 8'h00);
        rd(OFF_STATUS, 8'h08, 8'h00);
        wr(OFF_CONTROL, 8'h0B);
        repeat (3) @(posedge mclk);
        #1;
        chk({7'h00, program_busy}, 8'h00);
        $display("test lock done");
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire

//--- verilog/etdl_div_if.sv
`timescale 1ns/1ps
`default_nettype none
interface etdl_div_if #(parameter int W = 11);
    logic [W-1:0] divisor;
    logic ref_evt;
    logic run;
    logic tick;
    modport ctrl (output divisor, output ref_evt, output run, input tick);
    modport div (input divisor, input ref_evt, input run, output tick);
endinterface : etdl_div_if
`default_nettype wire

//--- verilog/etdl_divider.sv
`timescale 1ns/1ps
`default_nettype none
module etdl_divider #(
    parameter int W = 11
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Divider link
    etdl_div_if.div lnk
);
    logic [W-1:0] cnt_q;
    logic tick_q;
    logic [W:0] next_cnt;

    assign next_cnt = {1'b0, cnt_q} + {{W{1'b0}}, 1'b1};
    assign lnk.tick = tick_q;

    // A divisor of 0 or 1 ticks on every reference event rather than hanging.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end
        else if (!lnk.run)
        begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end
        else if (lnk.ref_evt)
        begin
            if (next_cnt >= {1'b0, lnk.divisor}) // R19
            begin
                cnt_q <= '0;
                tick_q <= 1'b1;
            end
            else
            begin
                cnt_q <= next_cnt[W-1:0];
                tick_q <= 1'b0;
            end
        end
        else
        begin
            tick_q <= 1'b0;
        end
    end
endmodule : etdl_divider
`default_nettype wire

//--- verilog/etdl_pkg.sv
// Overview of operation
// R01: An 11-bit divisor spans two byte registers and sets the 35 us timebase.
// R02: The divisor divides the selected crystal or bus reference clock into the timebase.
// R03: Every reset reloads both divisor registers from their nonvolatile shadow bytes.
// R04: Lock disable 0 locks the divisor; locked registers, that bit too, ignore writes.
// R05: While locked, program and erase of both shadow bytes are refused.
// R06: Divisor bits read always and write only with latch clear and lock disabled.
// R07: Software picks divisor as reference hertz times 35 us plus one half, truncated.
// R08: Software must not program or erase with a wrong divisor.
// R09: Shadow bytes are erased and programmed by the ordinary latch and program sequence.
// R10: A shadow lock disable bit of 0 makes the lock permanent after the next reset.
// R11: Wait mode leaves a running program or erase sequence untouched.
// R12: Stop mode brings the block's power use down to its minimum.
// R13: Software should not enter stop mode while a sequence runs.
// R14: Stop with latch and program enable set halts, drops high voltage, restarts on exit.
// R15: After a restart on stop exit, array access is blocked until that sequence ends.
// R16: Stop with latch and program enable not both set ends any sequence abruptly.
// R17: The latch bit steers bus writes into capturing a target location and value.
// R18: Program enable runs the charge pump only with latch set and a valid target.
// R19: The divider counts reference cycles, ticks when the count meets the divisor, restarts.
package etdl_pkg;
    localparam int DIV_W = 11;
    localparam int ADDR_W = 3;
    localparam int CLK_HZ = 50_000_000;
    localparam int TIMEBASE_US = 35;
    // Divisor software would load for the bus clock at this rate.
    localparam int BUS_DIVISOR = (CLK_HZ / 1000 * TIMEBASE_US + 500) / 1000;

    localparam logic [ADDR_W-1:0] OFF_DIV_HIGH = 3'h0;
    localparam logic [ADDR_W-1:0] OFF_DIV_LOW = 3'h1;
    localparam logic [ADDR_W-1:0] OFF_SHADOW_HIGH = 3'h2;
    localparam logic [ADDR_W-1:0] OFF_SHADOW_LOW = 3'h3;
    localparam logic [ADDR_W-1:0] OFF_CONTROL = 3'h4;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 3'h5;

    localparam int HIGH_LOCK_DISABLE_BIT = 7;
    localparam int CTRL_LATCH_BIT = 0;
    localparam int CTRL_PGM_BIT = 1;
    localparam int CTRL_ERASE_BIT = 2;
    localparam int CTRL_REFSEL_BIT = 3;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_RESTART_BIT = 1;
    localparam int STAT_LOCKED_BIT = 2;
    localparam int STAT_VALID_BIT = 3;
    localparam int STAT_STOP_BIT = 4;
    localparam int STAT_WAIT_BIT = 5;

    localparam logic [7:0] SHADOW_ERASED = 8'hFF;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [DIV_W-1:0] DIV_RESET = 11'h000;
    localparam logic [15:0] PROG_TICKS_DEFAULT = 16'h0064;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN, SEQ_HALT} etdl_seq_e;
endpackage : etdl_pkg

//--- verilog/etdl_top.sv
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module etdl_top #(
    parameter logic [15:0] PROG_TICKS = etdl_pkg::PROG_TICKS_DEFAULT
) (
    // Clock and resets
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic por_n,
    // Register port
    input wire logic [etdl_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Reference and power modes
    input wire logic crystal_reference_clock,
    input wire logic stop_mode,
    input wire logic wait_mode,
    // Array side
    output logic charge_pump_en,
    output logic array_access_block,
    output logic timebase_tick,
    output logic program_busy
);
    import etdl_pkg::*;

    logic [7:0] shadow_high_q;
    logic [7:0] shadow_low_q;
    logic divisor_lock_disable_q;
    logic [DIV_W-1:0] timebase_divisor_value_q;
    logic load_pending_q;
    logic bus_latch_control_q;
    logic program_voltage_enable_q;
    logic erase_sel_q;
    logic refsel_q;
    logic valid_q;
    logic target_high_q;
    logic [7:0] target_data_q;
    logic restart_q;
    logic stop_seen_q;
    logic [15:0] tick_cnt_q;
    logic [7:0] rdata_q;
    etdl_seq_e seq_q;
    logic locked;
    logic div_writable;
    logic wr_ctrl;
    logic seq_done;
    logic stop_entry;
    logic stop_abort;
    logic [7:0] status_byte;

    etdl_div_if #(.W(DIV_W)) div_lnk ();

    etdl_divider #(.W(DIV_W)) u_divider (
        .mclk (mclk),
        .rst_n (rst_n),
        .lnk (div_lnk)
    );

    assign locked = !divisor_lock_disable_q; // R04
    assign div_writable = !bus_latch_control_q && divisor_lock_disable_q && !load_pending_q; // R06
    assign wr_ctrl = reg_wr && (reg_addr == OFF_CONTROL);
    assign stop_entry = stop_mode && !stop_seen_q;
    // Latch and enable not both set: anything under way is dropped, nothing resumes.
    assign stop_abort = stop_entry && !(bus_latch_control_q && program_voltage_enable_q); // R16
    assign seq_done = (seq_q == SEQ_RUN) && !stop_mode && timebase_tick
        && (tick_cnt_q == PROG_TICKS - 16'h0001);

    // The divider halts in stop so the timebase stops toggling; wait mode does not touch it.
    assign div_lnk.run = !stop_mode; // R12 R11
    assign div_lnk.ref_evt = refsel_q ? 1'b1 : crystal_reference_clock; // R02
    assign div_lnk.divisor = timebase_divisor_value_q; // R01
    assign timebase_tick = div_lnk.tick;

    assign charge_pump_en = (seq_q == SEQ_RUN) && !stop_mode; // R18 R14 R12
    assign array_access_block = restart_q || (seq_q == SEQ_HALT); // R15
    assign program_busy = (seq_q != SEQ_IDLE);
    assign reg_rdata = rdata_q;

    // The shadow bytes model nonvolatile cells, so only power-on clears them, to the erased state.
    always_ff @(posedge mclk or negedge por_n)
    begin
        if (!por_n)
        begin
            shadow_high_q <= SHADOW_ERASED;
            shadow_low_q <= SHADOW_ERASED;
        end
        else if (seq_done)
        begin
            if (target_high_q) // R09
            begin
                shadow_high_q <= erase_sel_q ? SHADOW_ERASED : (shadow_high_q & target_data_q);
            end
            else
            begin
                shadow_low_q <= erase_sel_q ? SHADOW_ERASED : (shadow_low_q & target_data_q);
            end
        end
    end

    // The live divisor resets to a constant and copies the shadow on the first edge after release.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            load_pending_q <= 1'b1;
            divisor_lock_disable_q <= 1'b0;
            timebase_divisor_value_q <= DIV_RESET;
        end
        else if (load_pending_q)
        begin
            load_pending_q <= 1'b0;
            divisor_lock_disable_q <= shadow_high_q[HIGH_LOCK_DISABLE_BIT]; // R03 R10
            timebase_divisor_value_q <= {shadow_high_q[DIV_W-9:0], shadow_low_q}; // R03
        end
        else if (reg_wr && div_writable)
        begin
            if (reg_addr == OFF_DIV_HIGH) // R04 R06
            begin
                divisor_lock_disable_q <= reg_wdata[HIGH_LOCK_DISABLE_BIT];
                timebase_divisor_value_q[DIV_W-1:8] <= reg_wdata[DIV_W-9:0];
            end
            else if (reg_addr == OFF_DIV_LOW) // R04 R06
            begin
                timebase_divisor_value_q[7:0] <= reg_wdata;
            end
        end
    end

    // Clearing latch and enable together clears only the enable, leaving time for high voltage to fall.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bus_latch_control_q <= 1'b0;
            program_voltage_enable_q <= 1'b0;
            erase_sel_q <= 1'b0;
            refsel_q <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
            begin
                erase_sel_q <= reg_wdata[CTRL_ERASE_BIT];
                refsel_q <= reg_wdata[CTRL_REFSEL_BIT];
                if (!program_voltage_enable_q)
                begin
                    bus_latch_control_q <= reg_wdata[CTRL_LATCH_BIT]; // R17
                end
            end
            if (seq_done || stop_abort)
            begin
                program_voltage_enable_q <= 1'b0; // R16
            end
            else if (wr_ctrl)
            begin
                program_voltage_enable_q <= reg_wdata[CTRL_PGM_BIT] && bus_latch_control_q && valid_q; // R18
            end
        end
    end

    // Target capture; a write to a shadow byte while latched is taken as the target, not stored.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            valid_q <= 1'b0;
            target_high_q <= 1'b0;
            target_data_q <= BYTE_ZERO;
        end
        else if (reg_wr && bus_latch_control_q && !program_voltage_enable_q && !locked
            && ((reg_addr == OFF_SHADOW_HIGH) || (reg_addr == OFF_SHADOW_LOW))) // R05 R17
        begin
            valid_q <= 1'b1;
            target_high_q <= (reg_addr == OFF_SHADOW_HIGH);
            target_data_q <= reg_wdata;
        end
        else if (stop_abort || !bus_latch_control_q)
        begin
            valid_q <= 1'b0; // R16
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stop_seen_q <= 1'b0;
        end
        else
        begin
            stop_seen_q <= stop_mode;
        end
    end

    // Sequence timer in timebase ticks; a halted sequence starts its timing over on stop exit.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            seq_q <= SEQ_IDLE;
            tick_cnt_q <= 16'h0000;
        end
        else
        begin
            unique case (seq_q)
                SEQ_IDLE:
                begin
                    tick_cnt_q <= 16'h0000;
                    if (program_voltage_enable_q && bus_latch_control_q && !stop_mode)
                    begin
                        seq_q <= SEQ_RUN; // R18
                    end
                end
                SEQ_RUN:
                begin
                    if (stop_mode)
                    begin
                        seq_q <= SEQ_HALT; // R14
                        tick_cnt_q <= 16'h0000;
                    end
                    else if (seq_done || !program_voltage_enable_q)
                    begin
                        seq_q <= SEQ_IDLE;
                        tick_cnt_q <= 16'h0000;
                    end
                    else if (timebase_tick)
                    begin
                        tick_cnt_q <= tick_cnt_q + 16'h0001;
                    end
                end
                SEQ_HALT:
                begin
                    tick_cnt_q <= 16'h0000;
                    if (!stop_mode)
                    begin
                        seq_q <= SEQ_RUN; // R14
                    end
                end
            endcase
        end
    end

    // The restart flag is set on leaving the halted state, which cannot coincide with completion.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            restart_q <= 1'b0;
        end
        else if ((seq_q == SEQ_HALT) && !stop_mode)
        begin
            restart_q <= 1'b1; // R15
        end
        else if (seq_done || (seq_q == SEQ_IDLE))
        begin
            restart_q <= 1'b0; // R15
        end
    end

    always_comb
    begin
        status_byte = BYTE_ZERO;
        status_byte[STAT_BUSY_BIT] = (seq_q != SEQ_IDLE);
        status_byte[STAT_RESTART_BIT] = restart_q;
        status_byte[STAT_LOCKED_BIT] = locked;
        status_byte[STAT_VALID_BIT] = valid_q;
        status_byte[STAT_STOP_BIT] = stop_mode;
        status_byte[STAT_WAIT_BIT] = wait_mode; // R11
    end

    // Read data stand only in the cycle after the read strobe; unmapped offsets read zero.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_q <= BYTE_ZERO;
        end
        else if (reg_rd)
        begin
            unique case (reg_addr)
                OFF_DIV_HIGH: rdata_q <= {divisor_lock_disable_q, 4'h0, timebase_divisor_value_q[DIV_W-1:8]}; // R06
                OFF_DIV_LOW: rdata_q <= timebase_divisor_value_q[7:0]; // R06
                OFF_SHADOW_HIGH: rdata_q <= array_access_block ? BYTE_ZERO : shadow_high_q; // R15
                OFF_SHADOW_LOW: rdata_q <= array_access_block ? BYTE_ZERO : shadow_low_q; // R15
                OFF_CONTROL: rdata_q <= {4'h0, refsel_q, erase_sel_q, program_voltage_enable_q, bus_latch_control_q};
                OFF_STATUS: rdata_q <= status_byte;
                default: rdata_q <= BYTE_ZERO;
            endcase
        end
        else
        begin
            rdata_q <= BYTE_ZERO;
        end
    end
endmodule : etdl_top
`default_nettype wire
